/* logic/clkgen_pkg.sv */
// What this block does
// - Internal fast oscillator gives 8 MHz source and halts during STOP.
// - Resonator oscillator runs 2 to 10 MHz and halts during STOP.
// - External clock on input pin is gated off internally during STOP.
// - Internal oscillator selected frees both oscillator pins as port pins.
// - External clock selected frees the second oscillator pin as port pin.
// - Source selection comes from configuration setting, never from a software register.
// - Slow 240 kHz oscillator; software stops it only if configuration allows.
// - Reset sets CPU divider and pre-divider registers to 02H.
// - CPU clock ratio from pre-divider and divider bits; other codes prohibited.
// - Peripheral clock is system clock/2 for pre-divider 01H, system clock/4 for 02H.
// - Divider and pre-divider registers accept bit and byte writes.
// - Slow oscillator mode register resets to 00H; bit or byte writes.
// - Mode bit 0 clear keeps slow oscillator running, set stops it.
// - If software stop forbidden, mode register has no effect.
// - If software stop forbidden, watchdog source fixed to slow oscillator.
// - Stabilization wait after STOP only with resonator source.
// - Wait select 00,01,10,11 gives 2^10, 2^12, 2^15, 2^17 periods.
// - Wait select register byte-written only; reset content undefined.
// - Wait counted from oscillation start, whatever released STOP.
// - Wait after reset release comes from configuration setting.
package clkgen_pkg;

    localparam logic [15:0] ADDR_SLOW_OSC_MODE   = 16'hff58;
    localparam logic [15:0] ADDR_CLOCK_PREDIV    = 16'hfff3;
    localparam logic [15:0] ADDR_STABILIZE_WAIT  = 16'hfff4;
    localparam logic [15:0] ADDR_CPU_CLOCK_DIV   = 16'hfffb;

    localparam logic [7:0]  RESET_SLOW_OSC_MODE  = 8'h00;
    localparam logic [7:0]  RESET_CLOCK_PREDIV   = 8'h02;
    localparam logic [7:0]  RESET_CPU_CLOCK_DIV  = 8'h02;

    localparam int          BIT_SLOW_OSC_HALT    = 0;
    localparam int          BIT_CPU_DIVIDE       = 1;
    localparam int          BIT_PREDIVIDE_LOW    = 0;
    localparam int          BIT_PREDIVIDE_HIGH   = 1;

    localparam logic [1:0]  SRC_INTERNAL         = 2'h0;
    localparam logic [1:0]  SRC_RESONATOR        = 2'h1;
    localparam logic [1:0]  SRC_EXTERNAL         = 2'h2;

    localparam int          WAIT_EXP_SEL0        = 10;
    localparam int          WAIT_EXP_SEL1        = 12;
    localparam int          WAIT_EXP_SEL2        = 15;
    localparam int          WAIT_EXP_SEL3        = 17;
    localparam int          WAIT_WIDTH           = 18;

    localparam int          DIV_WIDTH            = 4;

endpackage : clkgen_pkg

/* logic/clock_divider.sv */
`timescale 1ns/100ps
`default_nettype none
// Divider counting only while run is high, producing one-cycle enables at system clock/2^n; enables stand in for divided clocks.
module clock_divider #(
    parameter int WIDTH = 4
) (
    input  wire logic             CLOCK,
    input  wire logic             SYS_RST,
    input  wire logic             run,
    output logic [WIDTH:0]        tick
);
    logic [WIDTH-1:0] count;

    initial begin
        if (WIDTH < 1) $error("clock_divider WIDTH must be at least 1");
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            count <= '0;
        end else if (run) begin
            count <= count + 1'b1;
        end
    end

    // Tick n pulses when the low n bits are all ones, one cycle in 2^n.
    genvar n;
    generate
        for (n = 0; n <= WIDTH; n++) begin : g_tick
            if (n == 0) begin : g_zero
                assign tick[n] = run;
            end else begin : g_pow
                assign tick[n] = run && (&count[n-1:0]);
            end
        end
    endgenerate
endmodule : clock_divider
`default_nettype wire

/* logic/system_clock_generator.sv */
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module system_clock_generator
    import clkgen_pkg::*;
#(
    parameter int BOOT_WAIT_CYCLES = 1024
) (
    input  wire logic                  CLOCK,
    input  wire logic                  SYS_RST,
    input  wire logic [31:0]           PADDR,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [31:0]           PWDATA,
    input  wire logic [3:0]            PSTRB,
    output logic [31:0]                PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire logic [1:0]            CFG_CLOCK_SOURCE,
    input  wire logic                  CFG_SLOW_STOP_ALLOWED,
    input  wire logic                  STOP_REQUEST,
    input  wire logic                  STOP_RELEASE,
    input  wire logic                  OSC_STARTED,
    output logic                       FAST_OSC_ENABLE,
    output logic                       RESONATOR_ENABLE,
    output logic                       EXT_CLOCK_GATE,
    output logic                       OSC_PIN_IN_IS_PORT,
    output logic                       OSC_PIN_OUT_IS_PORT,
    output logic                       SLOW_OSC_ENABLE,
    output logic                       WATCHDOG_SRC_FIXED,
    output logic                       CPU_CLOCK_EN,
    output logic                       PERIPH_CLOCK_EN,
    output logic                       CPU_CLOCK_HOLD,
    output logic                       DIVIDER_PROHIBITED
);
    import clkgen_pkg::*;

    typedef enum logic [3:0] {
        ST_BOOT_WAIT = 4'b0001,
        ST_RUN       = 4'b0010,
        ST_STOPPED   = 4'b0100,
        ST_STAB_WAIT = 4'b1000
    } clk_state_e;

    initial begin
        if (BOOT_WAIT_CYCLES < 1) $error("BOOT_WAIT_CYCLES must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus.

    logic [7:0]            slow_osc_mode;
    logic [7:0]            clock_predivider;
    logic [1:0]            stabilize_wait_select;
    logic                  cpu_divide_bit;
    logic                  bus_write;
    logic                  bus_read;
    logic [1:0]            lane;
    logic [7:0]            wbyte;
    logic                  wlane;
    logic                  hit_mode;
    logic                  hit_prediv;
    logic                  hit_wait;
    logic                  hit_div;
    logic [7:0]            next_rdata;

    assign bus_write  = PSEL && PENABLE && PWRITE && PREADY;
    assign bus_read   = PSEL && !PENABLE && !PWRITE;
    assign lane       = PADDR[1:0];
    assign wbyte      = PWDATA[8*lane +: 8];
    assign wlane      = PSTRB[lane];
    assign hit_mode   = PADDR[15:0] == ADDR_SLOW_OSC_MODE;
    assign hit_prediv = PADDR[15:0] == ADDR_CLOCK_PREDIV;
    assign hit_wait   = PADDR[15:0] == ADDR_STABILIZE_WAIT;
    assign hit_div    = PADDR[15:0] == ADDR_CPU_CLOCK_DIV;

    // No wait state: PREADY rises in the first access cycle, so every transfer takes two cycles.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            PSLVERR <= 1'b0;
        end else begin
            PSLVERR <= PSEL && !PENABLE && (PADDR[31:16] != 16'h0000 ||
                       !(hit_mode || hit_prediv || hit_wait || hit_div));
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (PADDR[31:16] == 16'h0000) begin
            if (hit_mode) begin
                next_rdata = slow_osc_mode;
            end else if (hit_prediv) begin
                next_rdata = clock_predivider;
            end else if (hit_wait) begin
                next_rdata = {6'h00, stabilize_wait_select};
            end else if (hit_div) begin
                next_rdata = {6'h00, cpu_divide_bit, 1'b0};
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (bus_read) begin
            PRDATA <= {24'h00_0000, next_rdata} << (8 * lane);
        end
    end

    // A single-bit write reaches the register as a byte write that carries the other bits back.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            cpu_divide_bit <= RESET_CPU_CLOCK_DIV[BIT_CPU_DIVIDE];
        end else if (bus_write && wlane && hit_div && PADDR[31:16] == 16'h0000) begin
            cpu_divide_bit <= wbyte[BIT_CPU_DIVIDE];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            clock_predivider <= RESET_CLOCK_PREDIV;
        end else if (bus_write && wlane && hit_prediv && PADDR[31:16] == 16'h0000) begin
            clock_predivider <= {6'h00, wbyte[BIT_PREDIVIDE_HIGH:BIT_PREDIVIDE_LOW]};
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            slow_osc_mode <= RESET_SLOW_OSC_MODE;
        end else if (bus_write && wlane && hit_mode && PADDR[31:16] == 16'h0000) begin
            slow_osc_mode <= {7'h00, wbyte[BIT_SLOW_OSC_HALT]};
        end
    end

    // Not reset: the content is undefined until software writes it.
    always_ff @(posedge CLOCK) begin
        if (bus_write && wlane && hit_wait && PADDR[31:16] == 16'h0000) begin
            stabilize_wait_select <= wbyte[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Source selection, STOP sequencing and stabilization wait.

    clk_state_e            state;
    logic [WAIT_WIDTH-1:0] wait_count;
    logic [WAIT_WIDTH-1:0] wait_limit;
    logic                  is_resonator;

    assign is_resonator = CFG_CLOCK_SOURCE == SRC_RESONATOR;

    always_comb begin
        case (stabilize_wait_select)
            2'b00:   wait_limit = WAIT_WIDTH'(1 << WAIT_EXP_SEL0);
            2'b01:   wait_limit = WAIT_WIDTH'(1 << WAIT_EXP_SEL1);
            2'b10:   wait_limit = WAIT_WIDTH'(1 << WAIT_EXP_SEL2);
            default: wait_limit = WAIT_WIDTH'(1 << WAIT_EXP_SEL3);
        endcase
    end

    // Boot wait length comes from the configuration-derived parameter, not from the wait select register.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state <= ST_BOOT_WAIT;
        end else begin
            case (state)
                ST_BOOT_WAIT: begin
                    if (!is_resonator || wait_count >= WAIT_WIDTH'(BOOT_WAIT_CYCLES - 1)) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (STOP_REQUEST) begin
                        state <= ST_STOPPED;
                    end
                end
                ST_STOPPED: begin
                    if (STOP_RELEASE) begin
                        state <= is_resonator ? ST_STAB_WAIT : ST_RUN;
                    end
                end
                ST_STAB_WAIT: begin
                    if (OSC_STARTED && wait_count >= wait_limit - 1'b1) begin
                        state <= ST_RUN;
                    end
                end
                default: state <= ST_BOOT_WAIT;
            endcase
        end
    end

    // In the stabilization wait the count only advances once the oscillator reports it is running; the boot wait counts without it.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            wait_count <= '0;
        end else if (state == ST_BOOT_WAIT && is_resonator) begin
            wait_count <= wait_count + 1'b1;
        end else if (state == ST_STAB_WAIT && OSC_STARTED) begin
            wait_count <= wait_count + 1'b1;
        end else begin
            wait_count <= '0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            FAST_OSC_ENABLE     <= 1'b0;
            RESONATOR_ENABLE    <= 1'b0;
            EXT_CLOCK_GATE      <= 1'b0;
            OSC_PIN_IN_IS_PORT  <= 1'b0;
            OSC_PIN_OUT_IS_PORT <= 1'b0;
            CPU_CLOCK_HOLD      <= 1'b1;
        end else begin
            FAST_OSC_ENABLE     <= CFG_CLOCK_SOURCE == SRC_INTERNAL && state != ST_STOPPED;
            RESONATOR_ENABLE    <= is_resonator && state != ST_STOPPED;
            EXT_CLOCK_GATE      <= CFG_CLOCK_SOURCE == SRC_EXTERNAL && state != ST_STOPPED;
            OSC_PIN_IN_IS_PORT  <= CFG_CLOCK_SOURCE == SRC_INTERNAL;
            OSC_PIN_OUT_IS_PORT <= CFG_CLOCK_SOURCE != SRC_RESONATOR;
            CPU_CLOCK_HOLD      <= state != ST_RUN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slow oscillator control.

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            SLOW_OSC_ENABLE    <= 1'b1;
            WATCHDOG_SRC_FIXED <= 1'b0;
        end else begin
            SLOW_OSC_ENABLE    <= !(CFG_SLOW_STOP_ALLOWED && slow_osc_mode[BIT_SLOW_OSC_HALT]);
            WATCHDOG_SRC_FIXED <= !CFG_SLOW_STOP_ALLOWED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divided clocks as enables.

    logic [DIV_WIDTH:0] tick;
    logic [2:0]         cpu_exp;
    logic [2:0]         periph_exp;
    logic               prohibited;

    clock_divider #(
        .WIDTH (DIV_WIDTH)
    ) u_divider (
        .CLOCK   (CLOCK),
        .SYS_RST (SYS_RST),
        .run     (state == ST_RUN),
        .tick    (tick)
    );

    always_comb begin
        prohibited = 1'b0;
        case ({clock_predivider[1:0], cpu_divide_bit})
            3'b000:  cpu_exp = 3'd0;
            3'b010:  cpu_exp = 3'd1;
            3'b001:  cpu_exp = 3'd2;
            3'b100:  cpu_exp = 3'd2;
            3'b011:  cpu_exp = 3'd3;
            3'b101:  cpu_exp = 3'd4;
            default: begin
                cpu_exp    = 3'd4;
                prohibited = 1'b1;
            end
        endcase
        case (clock_predivider[1:0])
            2'b00:   periph_exp = 3'd0;
            2'b01:   periph_exp = 3'd1;
            default: periph_exp = 3'd2;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            CPU_CLOCK_EN       <= 1'b0;
            PERIPH_CLOCK_EN    <= 1'b0;
            DIVIDER_PROHIBITED <= 1'b0;
        end else begin
            CPU_CLOCK_EN       <= tick[cpu_exp];
            PERIPH_CLOCK_EN    <= tick[periph_exp];
            DIVIDER_PROHIBITED <= prohibited;
        end
    end
endmodule : system_clock_generator
`default_nettype wire

/* tb/system_clock_generator_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module clkgen_checker
    import clkgen_pkg::*;
#(
    parameter int BOOT_WAIT_CYCLES = 1024
) (
    input wire logic       CLOCK,
    input wire logic       SYS_RST,
    input wire logic       PSLVERR,
    input wire logic [1:0] CFG_CLOCK_SOURCE,
    input wire logic       CFG_SLOW_STOP_ALLOWED,
    input wire logic       STOP_RELEASE,
    input wire logic       FAST_OSC_ENABLE,
    input wire logic       RESONATOR_ENABLE,
    input wire logic       EXT_CLOCK_GATE,
    input wire logic       OSC_PIN_IN_IS_PORT,
    input wire logic       OSC_PIN_OUT_IS_PORT,
    input wire logic       SLOW_OSC_ENABLE,
    input wire logic       WATCHDOG_SRC_FIXED,
    input wire logic       CPU_CLOCK_HOLD
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    // Outputs follow the configuration only from the second edge after reset, so checks wait for this.
    logic live;
    always_ff @(posedge CLOCK) begin
        live <= !SYS_RST;
    end

    gate_off_a: assert property ($rose(CPU_CLOCK_HOLD) |-> !FAST_OSC_ENABLE && !RESONATOR_ENABLE && !EXT_CLOCK_GATE)
        else $error("clock source left running in stop");
    int_pins_a: assert property (live && CFG_CLOCK_SOURCE == SRC_INTERNAL |-> OSC_PIN_IN_IS_PORT && OSC_PIN_OUT_IS_PORT)
        else $error("pins not freed for internal source");
    ext_pins_a: assert property (live && CFG_CLOCK_SOURCE == SRC_EXTERNAL |-> OSC_PIN_OUT_IS_PORT && !OSC_PIN_IN_IS_PORT)
        else $error("pin use wrong for external source");
    src_only_a: assert property (live && CFG_CLOCK_SOURCE == SRC_INTERNAL |-> !RESONATOR_ENABLE && !EXT_CLOCK_GATE)
        else $error("unselected source enabled");
    slow_keep_a: assert property (live && !CFG_SLOW_STOP_ALLOWED |-> SLOW_OSC_ENABLE)
        else $error("slow oscillator stopped though locked");
    wdog_fixed_a: assert property (live |-> WATCHDOG_SRC_FIXED == !$past(CFG_SLOW_STOP_ALLOWED))
        else $error("watchdog source flag wrong");
    quick_exit_a: assert property (live && STOP_RELEASE && CPU_CLOCK_HOLD && (CFG_CLOCK_SOURCE == SRC_INTERNAL
        || CFG_CLOCK_SOURCE == SRC_EXTERNAL) |-> ##[1:3] !CPU_CLOCK_HOLD)
        else $error("wait inserted for non-resonator source");
    res_wait_a: assert property (live && STOP_RELEASE && CPU_CLOCK_HOLD && CFG_CLOCK_SOURCE == SRC_RESONATOR
        |=> CPU_CLOCK_HOLD [*8])
        else $error("resonator released without wait");

    stop_seen_c: cover property ($rose(CPU_CLOCK_HOLD));
    slow_halt_c: cover property (!SLOW_OSC_ENABLE);
    bad_addr_c: cover property (PSLVERR);
endmodule : clkgen_checker

bind system_clock_generator clkgen_checker #(.BOOT_WAIT_CYCLES(BOOT_WAIT_CYCLES)) chk_u (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSLVERR(PSLVERR), .CFG_CLOCK_SOURCE(CFG_CLOCK_SOURCE),
    .CFG_SLOW_STOP_ALLOWED(CFG_SLOW_STOP_ALLOWED), .STOP_RELEASE(STOP_RELEASE), .FAST_OSC_ENABLE(FAST_OSC_ENABLE),
    .RESONATOR_ENABLE(RESONATOR_ENABLE), .EXT_CLOCK_GATE(EXT_CLOCK_GATE), .OSC_PIN_IN_IS_PORT(OSC_PIN_IN_IS_PORT),
    .OSC_PIN_OUT_IS_PORT(OSC_PIN_OUT_IS_PORT), .SLOW_OSC_ENABLE(SLOW_OSC_ENABLE),
    .WATCHDOG_SRC_FIXED(WATCHDOG_SRC_FIXED), .CPU_CLOCK_HOLD(CPU_CLOCK_HOLD)
);
`default_nettype wire

/* tb/test_system_clock_generator.sv */
`timescale 1ns/100ps
`default_nettype none
module test_system_clock_generator;
    import clkgen_pkg::*;
    logic        clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        stop_request = 1'b0, stop_release = 1'b0, osc_started = 1'b1, cfg_allow = 1'b1;
    logic [1:0]  cfg_src = 2'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, r;
    logic        pready, pslverr, fast_en, res_en, ext_gate, pin_in, pin_out, slow_en, wd_fixed;
    logic        cpu_en, per_en, hold, prohib;
    logic [32:0] exp_q[$];
    int          miscompares = 0, samples_checked = 0, p;
    logic [2:0]  codes [6] = '{3'b000, 3'b010, 3'b001, 3'b100, 3'b011, 3'b101};
    int          cpu_div [6] = '{1, 2, 4, 4, 8, 16};

    system_clock_generator #(.BOOT_WAIT_CYCLES(8)) dut_u (
        .CLOCK(clock), .SYS_RST(sys_rst), .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CFG_CLOCK_SOURCE(cfg_src), .CFG_SLOW_STOP_ALLOWED(cfg_allow), .STOP_REQUEST(stop_request),
        .STOP_RELEASE(stop_release), .OSC_STARTED(osc_started), .FAST_OSC_ENABLE(fast_en),
        .RESONATOR_ENABLE(res_en), .EXT_CLOCK_GATE(ext_gate), .OSC_PIN_IN_IS_PORT(pin_in),
        .OSC_PIN_OUT_IS_PORT(pin_out), .SLOW_OSC_ENABLE(slow_en), .WATCHDOG_SRC_FIXED(wd_fixed),
        .CPU_CLOCK_EN(cpu_en), .PERIPH_CLOCK_EN(per_en), .CPU_CLOCK_HOLD(hold), .DIVIDER_PROHIBITED(prohib)
    );

    always #50 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////
    // One APB transfer; entered and left just after a rising edge.
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [7:0] wd, input logic [7:0] rd,
                        input logic err);
        logic [4:0] sh;
        int         n;
        sh = {addr[1:0], 3'b000};
        n = 0;
        exp_q.push_back({err, wr ? 32'h0000_0000 : {24'h00_0000, rd} << sh});
        psel <= 1'b1;
        paddr <= addr;
        pwrite <= wr;
        pwdata <= {24'h00_0000, wd} << sh;
        pstrb <= 4'h1 << addr[1:0];
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : xfer

    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1) begin
            check({pslverr, pwrite ? 32'h0000_0000 : prdata}, exp_q.pop_front());
        end
    end

    task automatic restart(input logic [1:0] src, input logic allow);
        int n;
        n = 0;
        sys_rst <= 1'b1;
        cfg_src <= src;
        cfg_allow <= allow;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        while (hold !== 1'b0 && n < 40) begin
            @(posedge clock);
            n++;
        end
        check(src == SRC_RESONATOR ? n >= 7 && n <= 13 : n <= 4, 1);
        check({pin_in, pin_out}, src == SRC_INTERNAL ? 2'b11 : src == SRC_EXTERNAL ? 2'b01 : 2'b00);
        check({fast_en, res_en, ext_gate}, 3'b100 >> src);
        check({slow_en, wd_fixed}, {1'b1, !allow});
        xfer(1'b0, ADDR_CPU_CLOCK_DIV, 8'h00, 8'h02, 1'b0);
        xfer(1'b0, ADDR_CLOCK_PREDIV, 8'h00, 8'h02, 1'b0);
        xfer(1'b0, ADDR_SLOW_OSC_MODE, 8'h00, 8'h00, 1'b0);
    endtask : restart

    // The resonator is held silent for 40 cycles so the wait must not start before it runs.
    task automatic stop_cycle(input logic [1:0] src, input logic [1:0] sel);
        int n;
        int lo;
        n = 0;
        lo = 40 + (sel == 2'h0 ? 1024 : 4096);
        xfer(1'b1, ADDR_STABILIZE_WAIT, {6'h00, sel}, 8'h00, 1'b0);
        xfer(1'b0, ADDR_STABILIZE_WAIT, 8'h00, {6'h00, sel}, 1'b0);
        stop_request <= 1'b1;
        osc_started <= 1'b0;
        @(posedge clock);
        stop_request <= 1'b0;
        repeat (3) @(posedge clock);
        check({fast_en, res_en, ext_gate, hold, cpu_en, per_en}, 6'b000100);
        stop_release <= 1'b1;
        @(posedge clock);
        stop_release <= 1'b0;
        while (hold !== 1'b0 && n < 6000) begin
            @(posedge clock);
            n++;
            if (n == 40) begin
                osc_started <= 1'b1;
            end
        end
        check(src == SRC_RESONATOR ? n >= lo - 1 && n <= lo + 4 : n <= 4, 1);
        check({fast_en, res_en, ext_gate}, 3'b100 >> src);
    endtask : stop_cycle

    initial begin
        r = 32'h5c69;
        @(posedge clock);
        restart(SRC_INTERNAL, 1'b1);
        for (int i = 0; i < 6; i++) begin
            xfer(1'b1, ADDR_CLOCK_PREDIV, {6'h00, codes[i][2:1]}, 8'h00, 1'b0);
            xfer(1'b1, ADDR_CPU_CLOCK_DIV, {6'h00, codes[i][0], 1'b0}, 8'h00, 1'b0);
            xfer(1'b0, ADDR_CPU_CLOCK_DIV, 8'h00, {6'h00, codes[i][0], 1'b0}, 1'b0);
            for (int k = 0; k < 2; k++) begin
                p = 0;
                while ((k == 1 ? per_en : cpu_en) !== 1'b1 && p < 40) begin
                    @(posedge clock);
                    p++;
                end
                @(posedge clock);
                p = 1;
                while ((k == 1 ? per_en : cpu_en) !== 1'b1 && p < 40) begin
                    @(posedge clock);
                    p++;
                end
                check(p, k == 1 ? 1 << codes[i][2:1] : cpu_div[i]);
            end
            check(prohib, 0);
        end
        xfer(1'b1, ADDR_CLOCK_PREDIV, 8'h03, 8'h00, 1'b0);
        xfer(1'b1, 32'h0001_fff3, 8'h01, 8'h00, 1'b1);
        xfer(1'b0, 32'h0000_ff00, 8'h00, 8'h00, 1'b1);
        xfer(1'b0, ADDR_CLOCK_PREDIV, 8'h00, 8'h03, 1'b0);
        check(prohib, 1);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            xfer(1'b1, ADDR_SLOW_OSC_MODE, r[7:0], 8'h00, 1'b0);
            @(posedge clock);
            check(slow_en, !r[0]);
            xfer(1'b0, ADDR_SLOW_OSC_MODE, 8'h00, {7'h00, r[0]}, 1'b0);
        end
        restart(SRC_INTERNAL, 1'b0);
        xfer(1'b1, ADDR_SLOW_OSC_MODE, 8'h01, 8'h00, 1'b0);
        @(posedge clock);
        check({slow_en, wd_fixed}, 2'b11);
        for (int s = 0; s < 3; s++) begin
            restart(s[1:0], 1'b1);
            stop_cycle(s[1:0], 2'h0);
            if (s == 1) begin
                stop_cycle(s[1:0], 2'h1);
            end
        end
        give_verdict();
    end

    initial begin
        repeat (30000) @(posedge clock);
        miscompares++;
        give_verdict();
    end
endmodule : test_system_clock_generator
`default_nettype wire
